/* design/timer3_control_status.v */
`timescale 1ns/100ps
`include "timer3_defs.vh"

module timer3_control_status #(
    parameter ADDR_W = 12
) (
    input  wire              mclk,
    input  wire              rst_n,
    input  wire [ADDR_W-1:0] awaddr,
    input  wire              awvalid,
    output reg               awready,
    input  wire [31:0]       wdata,
    input  wire [3:0]        wstrb,
    input  wire              wvalid,
    output reg               wready,
    output reg  [1:0]        bresp,
    output reg               bvalid,
    input  wire              bready,
    input  wire [ADDR_W-1:0] araddr,
    input  wire              arvalid,
    output reg               arready,
    output reg  [31:0]       rdata,
    output reg  [1:0]        rresp,
    output reg               rvalid,
    input  wire              rready,
    input  wire              comparatorIn,
    input  wire              extOscIn,
    input  wire              lowUseSysClk,
    input  wire              highUseSysClk,
    input  wire              timerIrqEnable,
    input  wire              lowRollover,
    input  wire              highRollover,
    output reg               lowCountTick,
    output reg               highCountTick,
    output reg               splitMode,
    output reg               captureMode,
    output reg               captureTrigger,
    output reg               irqRequest,
    output reg  [7:0]        controlOut
);

// =====================================================================
// register bus
reg  [ADDR_W-1:0] awAddrHeld;
reg               awHeld;
reg  [7:0]        wDataHeld;
reg               wStrbHeld;
reg               wHeld;
reg  [7:0]        control;
reg  [7:0]        next_control;
wire              writeHit;
wire              readHit;
wire              bothHeld;
wire              doWrite;

// one register, so a single compare on the whole address decodes it
function isCtrlAddr;
    input [ADDR_W-1:0] addr;
    begin
        isCtrlAddr = (addr == `T3_CTRL_ADDR);
    end
endfunction

assign writeHit = isCtrlAddr(awAddrHeld);
assign readHit  = isCtrlAddr(araddr);
assign bothHeld = awHeld && wHeld && !bvalid;
// a cleared byte-0 strobe answers OKAY but leaves the register alone
assign doWrite  = bothHeld && writeHit && wStrbHeld;

// =====================================================================
// write address channel
always @(posedge mclk) begin
    if (!rst_n) begin
        awready    <= 1'b0;
        awHeld     <= 1'b0;
        awAddrHeld <= {ADDR_W{1'b0}};
    end else begin
        if (awvalid && awready) begin
            awAddrHeld <= awaddr;
            awHeld     <= 1'b1;
            awready    <= 1'b0;
        end else if (bothHeld) begin
            awHeld <= 1'b0;
        end else if (!awHeld && !bvalid) begin
            awready <= 1'b1;
        end
    end
end

// =====================================================================
// write data channel: only the low byte lane reaches the register
always @(posedge mclk) begin
    if (!rst_n) begin
        wready    <= 1'b0;
        wHeld     <= 1'b0;
        wDataHeld <= 8'h00;
        wStrbHeld <= 1'b0;
    end else begin
        if (wvalid && wready) begin
            wDataHeld <= wdata[7:0];
            wStrbHeld <= wstrb[0];
            wHeld     <= 1'b1;
            wready    <= 1'b0;
        end else if (bothHeld) begin
            wHeld <= 1'b0;
        end else if (!wHeld && !bvalid) begin
            wready <= 1'b1;
        end
    end
end

// =====================================================================
// write response channel
always @(posedge mclk) begin
    if (!rst_n) begin
        bvalid <= 1'b0;
        bresp  <= `AXI_OKAY;
    end else begin
        if (bothHeld) begin
            bvalid <= 1'b1;
            bresp  <= writeHit ? `AXI_OKAY : `AXI_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end
end

// =====================================================================
// read channel
// reads answer one cycle after the address is taken
always @(posedge mclk) begin
    if (!rst_n) begin
        arready <= 1'b0;
        rvalid  <= 1'b0;
        rdata   <= 32'h00000000;
        rresp   <= `AXI_OKAY;
    end else begin
        if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            if (readHit) begin
                rdata <= {24'h000000, control};
                rresp <= `AXI_OKAY;
            end else begin
                rdata <= 32'h00000000;
                rresp <= `AXI_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end
end

// =====================================================================
// clock sources
reg  [1:0] compSync;
reg        compPrev;
reg  [1:0] oscSync;
reg        oscPrev;
reg  [2:0] oscCount;
reg  [3:0] sysCount;
wire       compEdge;
wire       oscEdge;
wire       oscDiv8;
wire       sysDiv12;

assign compEdge = compSync[1] && !compPrev;
assign oscEdge  = oscSync[1] && !oscPrev;
assign oscDiv8  = oscEdge && (oscCount == `T3_OSC_DIV);
assign sysDiv12 = (sysCount == `T3_SYS_DIV - 4'h1);

// pins pass two flops before the edge detect; only stage 1 is read
// the divider runs free, so its first tick after a select may come early
always @(posedge mclk) begin
    if (!rst_n) begin
        compSync <= 2'h0;
        compPrev <= 1'b0;
        oscSync  <= 2'h0;
        oscPrev  <= 1'b0;
        oscCount <= 3'h0;
        sysCount <= 4'h0;
    end else begin
        compSync <= {compSync[0], comparatorIn};
        compPrev <= compSync[1];
        oscSync  <= {oscSync[0], extOscIn};
        oscPrev  <= oscSync[1];
        if (oscEdge)
            oscCount <= oscCount + 3'h1;
        sysCount <= sysDiv12 ? 4'h0 : sysCount + 4'h1;
    end
end

// =====================================================================
// clock and trigger selection
reg  extTick;
reg  trigTick;
wire lowTick;
wire highTick;

always @* begin
    case (control[`T3_CLKSEL_HI:`T3_CLKSEL_LO])
        `T3_SEL_SYSDIV: begin
            extTick  = sysDiv12;
            trigTick = compEdge;
        end
        `T3_SEL_OSC: begin
            extTick  = oscDiv8;
            trigTick = oscDiv8;
        end
        `T3_SEL_COMP: begin
            extTick  = compEdge;
            trigTick = oscDiv8;
        end
        default: begin
            // code 10 is reserved: the external tick and the trigger stay idle
            extTick  = 1'b0;
            trigTick = 1'b0;
        end
    endcase
end

// a byte set to the system clock ticks on every cycle
function pickTick;
    input useSys;
    input ext;
    begin
        pickTick = useSys | ext;
    end
endfunction

assign lowTick  = pickTick(lowUseSysClk, extTick);
assign highTick = pickTick(highUseSysClk, extTick);

// =====================================================================
// control register and flags
always @* begin
    next_control = control;
    if (doWrite)
        next_control = wDataHeld;
    // hardware events are applied last so they win over a clear
    if (lowRollover)
        next_control[`T3_LOW_FLAG] = 1'b1;
    if (highRollover)
        next_control[`T3_HIGH_FLAG] = 1'b1;
    // a capture also marks the high flag so it can interrupt
    if (control[`T3_CAPTURE_EN] && trigTick)
        next_control[`T3_HIGH_FLAG] = 1'b1;
end

always @(posedge mclk) begin
    if (!rst_n)
        control <= `T3_CTRL_RESET;
    else
        control <= next_control;
end

// =====================================================================
// mode levels and capture strobe to the counting core
always @(posedge mclk) begin
    if (!rst_n) begin
        splitMode      <= 1'b0;
        captureMode    <= 1'b0;
        captureTrigger <= 1'b0;
    end else begin
        splitMode   <= control[`T3_SPLIT];
        captureMode <= control[`T3_CAPTURE_EN];
        // core latches the count into reload on this pulse
        captureTrigger <= control[`T3_CAPTURE_EN] && trigTick;
    end
end

// =====================================================================
// count ticks to the counting core
always @(posedge mclk) begin
    if (!rst_n) begin
        lowCountTick  <= 1'b0;
        highCountTick <= 1'b0;
    end else if (control[`T3_SPLIT]) begin
        lowCountTick  <= lowTick;
        highCountTick <= highTick && control[`T3_RUN];
    end else begin
        // one tick drives the whole 16-bit count
        lowCountTick  <= lowTick && control[`T3_RUN];
        highCountTick <= 1'b0;
    end
end

// =====================================================================
// interrupt request and register copy
// the request is a level, so a flag left set keeps asking
always @(posedge mclk) begin
    if (!rst_n) begin
        irqRequest <= 1'b0;
        controlOut <= `T3_CTRL_RESET;
    end else begin
        irqRequest <= timerIrqEnable &&
                      (control[`T3_HIGH_FLAG] ||
                       (control[`T3_LOW_IRQ_EN] &&
                        control[`T3_LOW_FLAG]));
        controlOut <= control;
    end
end

endmodule

/* include/timer3_defs.vh */
// Overview of operation
// - upper byte wrap sets high flag
// - full 16-bit wrap sets high flag
// - high flag requests irq when enabled
// - lower byte wrap sets low flag
// - low flag set in every mode
// - flags stay set until software clears
// - low flag irq needs both enables
// - capture enable latches count on trigger
// - split bit gives two 8-bit timers
// - split clear gives one 16-bit timer
// - run gates the 16-bit count and the split upper byte, split gates upper
// - clock select picks clock and trigger
`ifndef TIMER3_DEFS_VH
`define TIMER3_DEFS_VH

// =====================================================================
// register map
`define T3_CTRL_INDEX    12'h091
`define T3_CTRL_ADDR     12'h244
`define T3_CTRL_RESET    8'h00

// =====================================================================
// control fields
`define T3_HIGH_FLAG     7
`define T3_LOW_FLAG      6
`define T3_LOW_IRQ_EN    5
`define T3_CAPTURE_EN    4
`define T3_SPLIT         3
`define T3_RUN           2
`define T3_CLKSEL_HI     1
`define T3_CLKSEL_LO     0

// =====================================================================
// clock select codes
`define T3_SEL_SYSDIV    2'h0
`define T3_SEL_OSC       2'h1
`define T3_SEL_COMP      2'h3

// =====================================================================
// timing
`define T3_SYS_DIV       4'hC
`define T3_OSC_DIV       3'h7

// =====================================================================
// bus responses
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2

`endif

/* testbench/timer3_ctrl_chk.sv */
`timescale 1ns/100ps
module timer3_ctrl_chk (
    input logic       mclk,
    input logic       rst_n,
    input logic       bvalid,
    input logic       lowRollover,
    input logic       highRollover,
    input logic       timerIrqEnable,
    input logic       lowCountTick,
    input logic       highCountTick,
    input logic       splitMode,
    input logic       captureMode,
    input logic       captureTrigger,
    input logic       irqRequest,
    input logic [7:0] controlOut
);
    // ========
    // flags, requests and ticks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_high_set:
        assert property (highRollover |-> ##2 controlOut[7])
        else $error("high flag not set");
    a_low_set:
        assert property (lowRollover |-> ##2 controlOut[6])
        else $error("low flag not set");
    a_flag_sticky:
        assert property ($fell(controlOut[7]) || $fell(controlOut[6])
                         |-> $past(bvalid))
        else $error("flag cleared without write");
    a_high_irq:
        assert property (controlOut[7] && $past(timerIrqEnable)
                         |-> irqRequest)
        else $error("missing high request");
    a_low_irq:
        assert property (&controlOut[6:5] && $past(timerIrqEnable)
                         |-> irqRequest)
        else $error("missing low request");
    a_irq_cause:
        assert property (irqRequest |-> $past(timerIrqEnable)
                         && (controlOut[7] || &controlOut[6:5]))
        else $error("request without cause");
    a_mode_follow:
        assert property (splitMode == controlOut[3]
                         && captureMode == controlOut[4])
        else $error("mode outputs disagree");
    a_upper_gate:
        assert property (highCountTick |-> &controlOut[3:2])
        else $error("upper tick while gated");
    a_whole_gate:
        assert property (lowCountTick && !controlOut[3] |-> controlOut[2])
        else $error("count tick while stopped");
    a_trig_mode:
        assert property (captureTrigger |-> controlOut[4])
        else $error("trigger outside capture");
    c_irq: cover property (irqRequest);
    c_trig: cover property (captureTrigger);
    c_upper: cover property (highCountTick);
endmodule

/* testbench/timer3_control_status_tb_top.sv */
`timescale 1ns/100ps
`include "timer3_defs.vh"
module timer3_control_status_tb_top;
    localparam logic [11:0] A = `T3_CTRL_ADDR;
    localparam logic [1:0]  OK = `AXI_OKAY, ER = `AXI_SLVERR;
    logic        mclk = '0, rst_n = '0, awvalid = '0, wvalid = '0;
    logic        bready = '1, arvalid = '0, rready = '1, comparatorIn = '0;
    logic        extOscIn = '0, lowUseSysClk = '0, highUseSysClk = '0;
    logic        timerIrqEnable = '0, lowRollover = '0, highRollover = '0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, irqRequest;
    logic        lowCountTick, highCountTick, splitMode, captureMode;
    logic        captureTrigger;
    logic [7:0]  controlOut;
    int          errorCnt = 0, testsRun = 0;
    timer3_control_status dut_u (.*);
    always #5 mclk = !mclk;
    // oscillator pin toggles every cycle: synced rising edge every 2
    always @(posedge mclk) extOscIn <= !extOscIn;
    // ========
    // bus and compare tasks
    task chk(input logic [33:0] g, e);
        testsRun++;
        if (g !== e) begin
            errorCnt++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task flg(input logic g, e);
        chk({33'h0, g}, {33'h0, e});
    endtask
    task tmo;
        errorCnt++;
        summarize;
    endtask
    // h pulses an upper wrap on the edge that writes the register
    task wr(input logic [11:0] a, input logic [7:0] d, input logic h,
            input logic [1:0] r);
        int n;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= '1;
        wvalid  <= '1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (bvalid) break;
            highRollover <= h & (awready | !awvalid) & (wready | !wvalid)
                            & (awvalid | wvalid);
            if (awready) awvalid <= '0;
            if (wready) wvalid <= '0;
        end
        if (n == 50) tmo;
        chk({bresp, 32'h0}, {r, 32'h0});
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
        int n;
        araddr  <= a;
        arvalid <= '1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (arready) arvalid <= '0;
            if (rvalid) break;
        end
        if (n == 50) tmo;
        chk({rresp, rdata}, {r, 24'h0, e});
    endtask
    task ev(input logic l, h);
        lowRollover  <= l;
        highRollover <= h;
        @(posedge mclk);
        lowRollover  <= '0;
        highRollover <= '0;
        repeat (3) @(posedge mclk);
    endtask
    task cnt(input int n, el, eh, ec);
        int l, h, c;
        l = 0;
        h = 0;
        c = 0;
        repeat (2) @(posedge mclk);
        repeat (n) begin
            @(posedge mclk);
            l += (lowCountTick === 1'h1);
            h += (highCountTick === 1'h1);
            c += (captureTrigger === 1'h1);
        end
        chk(34'(l * 65536 + h * 256 + c), 34'(el * 65536 + eh * 256 + ec));
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ========
    // sequence
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= '1;
        @(posedge mclk);
        rd(A, 8'h00, OK);
        wr(A, 8'h2C, '0, OK);
        wr(12'h240, 8'hFF, '0, ER);
        rd(12'h240, 8'h00, ER);
        rd(A, 8'h2C, OK);
        flg(splitMode, '1);
        $display("test 1 done");
        ev('1, '0);
        rd(A, 8'h6C, OK);
        flg(irqRequest, '0);
        timerIrqEnable <= '1;
        repeat (3) @(posedge mclk);
        flg(irqRequest, '1);
        wr(A, 8'h0C, '0, OK);
        rd(A, 8'h0C, OK);
        flg(irqRequest, '0);
        $display("test 2 done");
        lowUseSysClk  <= '1;
        highUseSysClk <= '1;
        cnt(10, 10, 10, 0);
        wr(A, 8'h08, '0, OK);
        cnt(10, 10, 0, 0);
        wr(A, 8'h00, '0, OK);
        cnt(10, 0, 0, 0);
        wr(A, 8'h04, '0, OK);
        cnt(10, 10, 0, 0);
        $display("test 3 done");
        ev('1, '0);
        rd(A, 8'h44, OK);
        flg(irqRequest, '0);
        ev('0, '1);
        rd(A, 8'hC4, OK);
        chk({26'h0, controlOut}, {26'h0, 8'hC4});
        flg(irqRequest, '1);
        wr(A, 8'h04, '1, OK);
        rd(A, 8'h84, OK);
        wr(A, 8'h04, '0, OK);
        rd(A, 8'h04, OK);
        $display("test 4 done");
        lowUseSysClk <= '0;
        cnt(24, 2, 0, 0);
        wr(A, 8'h05, '0, OK);
        cnt(32, 2, 0, 0);
        wr(A, 8'h17, '0, OK);
        cnt(32, 0, 0, 2);
        $display("test 5 done");
        lowUseSysClk <= '1;
        wr(A, 8'h14, '0, OK);
        comparatorIn <= '1;
        cnt(12, 12, 0, 1);
        rd(A, 8'h94, OK);
        flg(captureMode, '1);
        $display("test 6 done");
        lowUseSysClk <= '0;
        comparatorIn <= '0;
        wr(A, 8'h15, '0, OK);
        cnt(32, 2, 0, 2);
        wr(A, 8'h07, '0, OK);
        comparatorIn <= '1;
        cnt(12, 1, 0, 0);
        wr(A, 8'h06, '0, OK);
        cnt(32, 0, 0, 0);
        wstrb <= 4'hE;
        wr(A, 8'hFF, '0, OK);
        wstrb <= 4'hF;
        rd(A, 8'h06, OK);
        $display("test 7 done");
        summarize;
    end
endmodule
bind timer3_control_status timer3_ctrl_chk chk_u (.*);
